// ===== common/atten_pkg.sv
// constants and types shared by the attenuator DAC control block
package atten_pkg;

    // serial frame layout
    localparam int DATA_W = 10;
    localparam int FRAME_W = 13;
    localparam int CNT_W = 4;
    localparam logic [3:0] FRAME_BITS = 4'hD;
    localparam logic [3:0] HEADER_LAST = 4'h2;
    localparam logic [3:0] TX_FIRST_SHIFT = 4'h4;
    localparam int RW_POS = 12;
    localparam int ADDR_HI = 11;
    localparam int ADDR_LO = 10;

    // register indices and contents
    localparam logic [1:0] REG_DIRECT = 2'h0;
    localparam logic [1:0] REG_STEP_UP = 2'h1;
    localparam logic [1:0] REG_STEP_DOWN = 2'h2;
    localparam logic [1:0] REG_READBACK = 2'h3;
    localparam logic [9:0] REG_RESET = 10'h000;
    localparam int READBACK_EN_POS = 9;
    localparam int COMP_STATE_POS = 8;
    localparam logic [9:0] CODE_MAX = 10'h3FF;
    localparam logic [9:0] CODE_MIN = 10'h000;

    // positions in the synchronised pin vector
    localparam int PIN_SCLK = 0;
    localparam int PIN_CS_N = 1;
    localparam int PIN_DIN = 2;
    localparam int PIN_UP_N = 3;
    localparam int PIN_DOWN_N = 4;
    localparam int PIN_DAC_SEL = 5;
    localparam int PIN_STEP_MODE = 6;
    localparam int PIN_COMP = 7;
    localparam int PIN_COUNT = 8;
    localparam logic [7:0] PIN_RESET = 8'h9A;

    // interrupt events
    localparam int EV_WRITE_DONE = 0;
    localparam int EV_WRITE_DROP = 1;
    localparam int EV_COMP_TRIP = 2;
    localparam int EV_STEP_SAT = 3;
    localparam int EV_W = 4;
    localparam logic [3:0] EV_NONE = 4'h0;

    // interrupt register port
    localparam int BUS_ADDR_W = 4;
    localparam int BUS_DATA_W = 8;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h0;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h4;
    localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h8;
    localparam logic [7:0] BUS_ZERO = 8'h00;

    typedef enum logic [3:0] {
        FR_IDLE = 4'b0001,
        FR_HEADER = 4'b0010,
        FR_READ = 4'b0100,
        FR_WRITE = 4'b1000
    } frame_state_type;

endpackage

// ===== common/step_if.sv
// step requests from the control block and the stepped code coming back
`timescale 1ns/1ps
interface step_if;
    logic up_step;
    logic down_step;
    logic clear;
    logic [9:0] increment;
    logic [9:0] decrement;
    logic [9:0] code;
    logic saturated;

    modport engine (
        input up_step,
        input down_step,
        input clear,
        input increment,
        input decrement,
        output code,
        output saturated
    );

    modport control (
        output up_step,
        output down_step,
        output clear,
        output increment,
        output decrement,
        input code,
        input saturated
    );
endinterface

// ===== dv/attenuator_dac_control_checker.sv
// assertion checker bound to the attenuator DAC control block
`timescale 1ns/1ps
module attenuator_dac_control_checker
    import atten_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic spi_cs_n,
    input wire logic spi_dout_oe,
    input wire logic dac_source_select,
    input wire logic step_mode,
    input wire logic comp_out,
    input wire logic [9:0] dac_code,
    input wire logic dac_enable,
    input wire logic ext_ctrl_switch,
    input wire logic dac_drive_switch,
    input wire logic compare_switch,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == BUS_ZERO)
        else $error("read data outside its slot");
    a_irq_masked: assert property (reg_write && reg_addr == ADDR_IRQ_ENABLE
        && reg_wdata == BUS_ZERO |=> ##1 !irq) else $error("irq with all masked");
    a_oe_idle: assert property (spi_cs_n [*6] |-> !spi_dout_oe)
        else $error("dout driven outside a frame");
    a_oe_start: assert property ($rose(spi_dout_oe) |-> !spi_cs_n)
        else $error("dout enabled while deselected");
    a_compare_path: assert property (compare_switch |->
        ext_ctrl_switch && dac_enable && !dac_drive_switch) else $error("bad compare state");
    a_dac_off: assert property (!dac_enable |->
        ext_ctrl_switch && !dac_drive_switch && !compare_switch) else $error("bad analog state");
    a_select_dac: assert property (dac_source_select [*6] |->
        dac_drive_switch && dac_enable && !compare_switch) else $error("DAC not driving");
    a_select_ctrl: assert property (!dac_source_select [*6] |->
        ext_ctrl_switch && !dac_drive_switch) else $error("control pin not driving");
    a_comp_idle: assert property (!compare_switch [*2] |-> comp_out)
        else $error("comparator low outside compare");
    a_code_hold: assert property ((!step_mode && spi_cs_n) [*8] |-> $stable(dac_code))
        else $error("code moved in register mode");
endmodule

bind attenuator_dac_control attenuator_dac_control_checker u_attenuator_dac_control_checker (
    .clock(clock), .nrst(nrst), .spi_cs_n(spi_cs_n), .spi_dout_oe(spi_dout_oe),
    .dac_source_select(dac_source_select), .step_mode(step_mode), .comp_out(comp_out),
    .dac_code(dac_code), .dac_enable(dac_enable), .ext_ctrl_switch(ext_ctrl_switch),
    .dac_drive_switch(dac_drive_switch), .compare_switch(compare_switch),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));

// ===== dv/attenuator_dac_control_test.sv
// self-checking bench for the attenuator DAC control block
`timescale 1ns/1ps
module attenuator_dac_control_test;
    import atten_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic dac_source_select = 1'b0;
    logic step_mode = 1'b0;
    logic comparator_in = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic rd_pend = 1'b0;
    logic [7:0] reg_rdata;
    logic [9:0] dac_code, got_data, r0, r1;
    logic spi_clk, spi_cs_n, spi_din, spi_dout, spi_dout_oe, up_n, down_n, got_valid;
    logic comp_out, dac_enable, ext_ctrl_switch, dac_drive_switch, compare_switch, irq;
    logic [9:0] exp_q[$];
    int n_mismatch = 0;
    int total_checks = 0;

    initial
    begin
        forever #5 clock = ~clock;
    end

    spi_host_model u_spi_host_model (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
        .spi_din(spi_din), .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe),
        .step_up_pulse_n(up_n), .step_down_pulse_n(down_n),
        .got_valid(got_valid), .got_data(got_data));

    attenuator_dac_control u_attenuator_dac_control (.clock(clock), .nrst(nrst),
        .clock_en(1'b1), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_din(spi_din),
        .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe), .step_up_pulse_n(up_n),
        .step_down_pulse_n(down_n), .dac_source_select(dac_source_select),
        .step_mode(step_mode), .comparator_in(comparator_in), .comp_out(comp_out),
        .dac_code(dac_code), .dac_enable(dac_enable), .ext_ctrl_switch(ext_ctrl_switch),
        .dac_drive_switch(dac_drive_switch), .compare_switch(compare_switch),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));

    task automatic check(input logic [9:0] seen, input logic [9:0] want);
        total_checks++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [9:0] want);
        exp_q.push_back(want);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    task automatic spi_rd(input logic [1:0] a, input logic [9:0] want);
        exp_q.push_back(want);
        u_spi_host_model.frame(1'b1, a, 10'h000, 13);
    endtask

    // select and mode pins, then time for the synchronisers
    task automatic pins(input logic sel, input logic mode);
        @(posedge clock);
        dac_source_select <= sel;
        step_mode <= mode;
        repeat (8) @(posedge clock);
    endtask

    function automatic logic [9:0] sw();
        return {6'h00, dac_enable, ext_ctrl_switch, dac_drive_switch, compare_switch};
    endfunction

    always @(posedge clock)
    begin
        if (rd_pend)
            check({2'b00, reg_rdata}, exp_q.pop_front());
        rd_pend <= reg_read;
    end

    always @(posedge got_valid)
        check(got_data, exp_q.pop_front());

    initial
    begin
        #500000;
        n_mismatch++;
        $display("timeout");
        print_verdict();
    end

    initial
    begin
        void'($urandom(87085));
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        check(dac_code, 10'h000);
        check(sw(), 10'h004);
        $display("test reset done");
        r0 = 10'($urandom);
        r1 = 10'($urandom);
        pins(1'b1, 1'b0);
        u_spi_host_model.frame(1'b0, REG_DIRECT, r0, 13);
        u_spi_host_model.frame(1'b0, REG_STEP_UP, r1, 13);
        u_spi_host_model.frame(1'b0, REG_STEP_DOWN, ~r1, 13);
        spi_rd(REG_DIRECT, r0);
        spi_rd(REG_STEP_UP, r1);
        spi_rd(REG_STEP_DOWN, ~r1);
        spi_rd(REG_READBACK, 10'h100);
        check(dac_code, r0);
        check(sw(), 10'h00A);
        u_spi_host_model.frame(1'b0, REG_DIRECT, ~r0, 12);
        check(dac_code, r0);
        spi_rd(REG_DIRECT, r0);
        $display("test serial registers done");
        reg_rd(ADDR_IRQ_STATUS, 10'h003);
        reg_wr(ADDR_IRQ_ENABLE, 8'h0F);
        repeat (3) @(posedge clock);
        check({9'h000, irq}, 10'h001);
        reg_wr(ADDR_IRQ_CLEAR, 8'h0F);
        reg_rd(ADDR_IRQ_STATUS, 10'h000);
        reg_rd(ADDR_IRQ_ENABLE, 10'h00F);
        reg_rd(ADDR_IRQ_CLEAR, 10'h000);
        reg_rd(4'hC, 10'h000);
        check({9'h000, irq}, 10'h000);
        $display("test interrupt port done");
        pins(1'b1, 1'b1);
        u_spi_host_model.frame(1'b0, REG_STEP_UP, 10'd700, 13);
        u_spi_host_model.frame(1'b0, REG_STEP_DOWN, 10'd5, 13);
        u_spi_host_model.step(1'b1, 1'b1);
        check(dac_code, 10'h000);
        u_spi_host_model.step(1'b0, 1'b1);
        check(dac_code, CODE_MIN);
        u_spi_host_model.step(1'b1, 1'b0);
        check(dac_code, 10'd700);
        u_spi_host_model.step(1'b1, 1'b0);
        check(dac_code, CODE_MAX);
        u_spi_host_model.step(1'b0, 1'b1);
        check(dac_code, 10'd1018);
        check({9'h000, irq}, 10'h001);
        pins(1'b1, 1'b0);
        check(dac_code, r0);
        u_spi_host_model.step(1'b1, 1'b0);
        u_spi_host_model.step(1'b1, 1'b1);
        pins(1'b1, 1'b1);
        check(dac_code, 10'd1018);
        u_spi_host_model.step(1'b1, 1'b1);
        check(dac_code, 10'h000);
        $display("test stepping done");
        pins(1'b0, 1'b0);
        u_spi_host_model.frame(1'b0, REG_READBACK, 10'h200, 13);
        check(sw(), 10'h00D);
        spi_rd(REG_READBACK, 10'h300);
        @(posedge clock);
        comparator_in <= 1'b0;
        repeat (8) @(posedge clock);
        check({9'h000, comp_out}, 10'h000);
        spi_rd(REG_READBACK, 10'h200);
        pins(1'b1, 1'b0);
        check(sw(), 10'h00E);
        u_spi_host_model.frame(1'b0, REG_READBACK, 10'h000, 13);
        pins(1'b0, 1'b0);
        check(sw(), 10'h004);
        reg_wr(ADDR_IRQ_ENABLE, 8'h00);
        repeat (3) @(posedge clock);
        check({9'h000, irq}, 10'h000);
        $display("test control states done");
        check(exp_q.size(), 10'h000);
        print_verdict();
    end
endmodule

// ===== dv/spi_host_model.sv
// behavioural serial host and step pulse source facing the attenuator block
`timescale 1ns/1ps
module spi_host_model (
    output logic spi_clk,
    output logic spi_cs_n,
    output logic spi_din,
    input wire logic spi_dout,
    input wire logic spi_dout_oe,
    output logic step_up_pulse_n,
    output logic step_down_pulse_n,
    output logic got_valid,
    output logic [9:0] got_data
);
    initial
    begin
        spi_clk = 1'b0;
        spi_cs_n = 1'b1;
        spi_din = 1'b0;
        step_up_pulse_n = 1'b1;
        step_down_pulse_n = 1'b1;
        got_valid = 1'b0;
        got_data = 10'h000;
    end

    // mode 0: din moves while the clock is low, the line is sampled on the rise;
    // the clock stands low between frames
    task automatic frame(input logic rw, input logic [1:0] a, input logic [9:0] d, input int n);
        logic [12:0] w;
        w = {rw, a, d};
        #3;
        spi_cs_n = 1'b0;
        for (int i = 12; i > 12 - n; i--)
        begin
            spi_din = w[i];
            #80 spi_clk = 1'b1;
            if (i < 10)
                got_data[i] = spi_dout_oe ? spi_dout : 1'bz;
            #80 spi_clk = 1'b0;
        end
        #80 spi_cs_n = 1'b1;
        spi_din = ~spi_din;
        got_valid = rw;
        #100 got_valid = 1'b0;
    endtask

    // a low pulse ends in the counted rising edge; both low together clears in step mode
    task automatic step(input logic up, input logic down);
        step_up_pulse_n = !up;
        step_down_pulse_n = !down;
        #160 step_up_pulse_n = 1'b1;
        step_down_pulse_n = 1'b1;
        #160;
    endtask
endmodule

// ===== hw/attenuator_dac_control.sv
// serial register set, control-state selection and DAC code logic of the attenuator
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// What this block does
// R01: with source select low and readback enable clear the DAC is off and the control pin rules.
// R02: with source select high and readback enable clear both attenuators follow the DAC code.
// R03: with select low and readback set the DAC runs and the comparator output falls when the control voltage passes it.
// R04: with select high and readback set the DAC output is routed onto the control pin, for test only.
// R05: four registers are reached by 13-bit serial frames carrying 10 data bits.
// R06: a frame starts with the read/write bit, then two address bits, then the data.
// R07: register 0 is the direct code, register 1 the step-up size, register 2 the step-down size.
// R08: with the mode pin low register 0 is the DAC code and the step pulses are ignored.
// R09: register 3 holds readback enable and reads back that bit with the comparator state.
// R10: with the mode pin high the code is up-steps times register 1 less down-steps times register 2.
// R11: the stepped code saturates at 1023 and at 0 instead of wrapping.
// R12: a write lands only when chip select rises after all 13 bits, otherwise it is dropped.
// R13: a read shifts the 10 register bits out MSB first and releases the output otherwise.
// R14: in step mode both step pulse inputs low together clear the stepped code to zero.
module attenuator_dac_control
    import atten_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic clock_en,
    input wire logic spi_clk,
    input wire logic spi_cs_n,
    input wire logic spi_din,
    output logic spi_dout,
    output logic spi_dout_oe,
    input wire logic step_up_pulse_n,
    input wire logic step_down_pulse_n,
    input wire logic dac_source_select,
    input wire logic step_mode,
    input wire logic comparator_in,
    output logic comp_out,
    output logic [9:0] dac_code,
    output logic dac_enable,
    output logic ext_ctrl_switch,
    output logic dac_drive_switch,
    output logic compare_switch,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic irq
);

    step_if steps ();

    step_engine engine (
        .clock(clock),
        .nrst(nrst),
        .clock_en(clock_en),
        .steps(steps)
    );

    function automatic logic reg_hit(input logic [1:0] addr, input logic [1:0] idx);
        reg_hit = (addr == idx);
    endfunction

    logic [7:0] pins;
    logic [7:0] sync1_q, sync1_d, sync2_q, sync2_d;
    logic sclk_prev_q, sclk_prev_d, cs_prev_q, cs_prev_d;
    logic up_prev_q, up_prev_d, down_prev_q, down_prev_d;
    frame_state_type state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [12:0] shift_q, shift_d;
    logic [9:0] tx_q, tx_d;
    logic dout_q, dout_d, oe_q, oe_d;
    logic [9:0] reg0_q, reg0_d, reg1_q, reg1_d, reg2_q, reg2_d;
    logic readback_enable_bit_q, readback_enable_bit_d;
    logic comp_q, comp_d;
    logic [9:0] code_q, code_d;
    logic dac_en_q, dac_en_d, s_ext_q, s_ext_d, s_dac_q, s_dac_d, s_cmp_q, s_cmp_d;
    logic [3:0] status_q, status_d, enable_q, enable_d;
    logic [7:0] rdata_q, rdata_d;
    logic irq_q, irq_d;
    logic sclk_rise, sclk_fall, cs_rise, cs_fall;
    logic up_now, down_now, dac_sel, mode_sync;
    logic [3:0] events;
    logic [3:0] clear_mask;
    logic [9:0] read_value;

    assign pins = {comparator_in, step_mode, dac_source_select, step_down_pulse_n,
                   step_up_pulse_n, spi_din, spi_cs_n, spi_clk};

    // every pin is foreign to this clock, edges are found after two stages
    always_comb
    begin
        sync1_d = pins;
        sync2_d = sync1_q;
        sclk_prev_d = sync2_q[PIN_SCLK];
        cs_prev_d = sync2_q[PIN_CS_N];
        up_prev_d = sync2_q[PIN_UP_N];
        down_prev_d = sync2_q[PIN_DOWN_N];
    end

    assign sclk_rise = sync2_q[PIN_SCLK] & ~sclk_prev_q;
    assign sclk_fall = ~sync2_q[PIN_SCLK] & sclk_prev_q;
    assign cs_rise = sync2_q[PIN_CS_N] & ~cs_prev_q;
    assign cs_fall = ~sync2_q[PIN_CS_N] & cs_prev_q;
    assign up_now = sync2_q[PIN_UP_N];
    assign down_now = sync2_q[PIN_DOWN_N];
    assign dac_sel = sync2_q[PIN_DAC_SEL];
    assign mode_sync = sync2_q[PIN_STEP_MODE];

    always_comb
    begin
        // in a read only the header has been shifted, so the address sits at the bottom
        unique case (shift_q[1:0])
            REG_DIRECT: read_value = reg0_q;
            REG_STEP_UP: read_value = reg1_q;
            REG_STEP_DOWN: read_value = reg2_q;
            REG_READBACK: read_value = {readback_enable_bit_q, comp_q, 8'h00}; // R09
        endcase
    end

    // serial frame engine
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        tx_d = tx_q;
        dout_d = dout_q;
        oe_d = oe_q;
        reg0_d = reg0_q;
        reg1_d = reg1_q;
        reg2_d = reg2_q;
        readback_enable_bit_d = readback_enable_bit_q;
        events = EV_NONE;
        if (sync2_q[PIN_CS_N])
        begin
            // a rising select ends any frame and releases the output at once
            state_d = FR_IDLE;
            oe_d = 1'b0; // R13
            if (cs_rise && state_q == FR_WRITE && cnt_q == FRAME_BITS) // R12
            begin
                events[EV_WRITE_DONE] = 1'b1;
                if (reg_hit(shift_q[ADDR_HI:ADDR_LO], REG_DIRECT))
                    reg0_d = shift_q[9:0]; // R07
                if (reg_hit(shift_q[ADDR_HI:ADDR_LO], REG_STEP_UP))
                    reg1_d = shift_q[9:0]; // R07
                if (reg_hit(shift_q[ADDR_HI:ADDR_LO], REG_STEP_DOWN))
                    reg2_d = shift_q[9:0]; // R07
                if (reg_hit(shift_q[ADDR_HI:ADDR_LO], REG_READBACK))
                    readback_enable_bit_d = shift_q[READBACK_EN_POS]; // R09
            end
            else if (cs_rise && (state_q == FR_WRITE || (state_q == FR_HEADER
                     && cnt_q != 4'h0)))
            begin
                events[EV_WRITE_DROP] = 1'b1; // R12
            end
        end
        else
        begin
            unique case (state_q)
                FR_IDLE:
                begin
                    if (cs_fall)
                    begin
                        state_d = FR_HEADER;
                        cnt_d = 4'h0;
                        shift_d = 13'h0000;
                    end
                end
                FR_HEADER:
                begin
                    if (sclk_rise)
                    begin
                        shift_d = {shift_q[11:0], sync2_q[PIN_DIN]}; // R06
                        cnt_d = cnt_q + 4'h1;
                        if (cnt_q == HEADER_LAST)
                        begin
                            if (shift_q[1]) // R06
                                state_d = FR_READ;
                            else
                                state_d = FR_WRITE;
                        end
                    end
                end
                FR_READ:
                begin
                    if (cnt_q == 4'h3 && !oe_q && tx_q == 10'h000 && !dout_q)
                    begin
                        tx_d = read_value; // R13
                        dout_d = read_value[9];
                        oe_d = 1'b1;
                        cnt_d = TX_FIRST_SHIFT;
                    end
                    else if (sclk_fall && cnt_q > TX_FIRST_SHIFT && cnt_q <= FRAME_BITS)
                    begin
                        tx_d = {tx_q[8:0], 1'b0}; // R13
                        dout_d = tx_q[8];
                    end
                    if (sclk_rise && cnt_q != 4'h3)
                    begin
                        cnt_d = (cnt_q < FRAME_BITS) ? cnt_q + 4'h1 : cnt_q;
                        // the host takes the last bit on this rise, so release only now
                        if (cnt_q >= FRAME_BITS)
                            oe_d = 1'b0; // R13
                    end
                end
                FR_WRITE:
                begin
                    if (sclk_rise && cnt_q < FRAME_BITS) // R05
                    begin
                        shift_d = {shift_q[11:0], sync2_q[PIN_DIN]};
                        cnt_d = cnt_q + 4'h1;
                    end
                end
                default:
                begin
                    state_d = FR_IDLE;
                end
            endcase
        end
        if (state_d == FR_IDLE)
        begin
            tx_d = 10'h000;
            dout_d = 1'b0;
        end
    end

    // control state, DAC code and comparator
    always_comb
    begin
        s_ext_d = ~dac_sel | readback_enable_bit_q; // R01 R03 R04
        s_dac_d = dac_sel; // R02 R04
        s_cmp_d = ~dac_sel & readback_enable_bit_q; // R03
        dac_en_d = dac_sel | readback_enable_bit_q; // R01
        comp_d = s_cmp_q ? sync2_q[PIN_COMP] : 1'b1; // R03
        code_d = mode_sync ? steps.code : reg0_q; // R08 R10
    end

    // step pulses count only in step mode, on a rising edge with the other pin high
    assign steps.up_step = mode_sync & up_now & ~up_prev_q & down_now & down_prev_q; // R08
    assign steps.down_step = mode_sync & down_now & ~down_prev_q & up_now & up_prev_q; // R08
    assign steps.clear = mode_sync & ~up_now & ~down_now; // R14
    assign steps.increment = reg1_q;
    assign steps.decrement = reg2_q;

    // interrupt registers; a new event beats a clear in the same cycle
    always_comb
    begin
        clear_mask = (reg_write && reg_addr == ADDR_IRQ_CLEAR) ? reg_wdata[3:0] : EV_NONE;
        enable_d = (reg_write && reg_addr == ADDR_IRQ_ENABLE) ? reg_wdata[3:0] : enable_q;
        status_d = (status_q & ~clear_mask) | {steps.saturated, comp_q & ~comp_d,
                   events[EV_WRITE_DROP], events[EV_WRITE_DONE]};
        irq_d = |(status_d & enable_d);
        rdata_d = BUS_ZERO;
        if (reg_read)
        begin
            if (reg_addr == ADDR_IRQ_STATUS)
                rdata_d = {4'h0, status_q};
            else if (reg_addr == ADDR_IRQ_ENABLE)
                rdata_d = {4'h0, enable_q};
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_q <= PIN_RESET;
            sync2_q <= PIN_RESET;
            sclk_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
            up_prev_q <= 1'b1;
            down_prev_q <= 1'b1;
            state_q <= FR_IDLE;
            cnt_q <= 4'h0;
            shift_q <= 13'h0000;
            tx_q <= 10'h000;
            dout_q <= 1'b0;
            oe_q <= 1'b0;
            reg0_q <= REG_RESET;
            reg1_q <= REG_RESET;
            reg2_q <= REG_RESET;
            readback_enable_bit_q <= 1'b0;
            comp_q <= 1'b1;
            code_q <= REG_RESET;
            dac_en_q <= 1'b0;
            s_ext_q <= 1'b1;
            s_dac_q <= 1'b0;
            s_cmp_q <= 1'b0;
            status_q <= EV_NONE;
            enable_q <= EV_NONE;
            rdata_q <= BUS_ZERO;
            irq_q <= 1'b0;
        end
        else if (clock_en)
        begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            sclk_prev_q <= sclk_prev_d;
            cs_prev_q <= cs_prev_d;
            up_prev_q <= up_prev_d;
            down_prev_q <= down_prev_d;
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            tx_q <= tx_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
            reg0_q <= reg0_d;
            reg1_q <= reg1_d;
            reg2_q <= reg2_d;
            readback_enable_bit_q <= readback_enable_bit_d;
            comp_q <= comp_d;
            code_q <= code_d;
            dac_en_q <= dac_en_d;
            s_ext_q <= s_ext_d;
            s_dac_q <= s_dac_d;
            s_cmp_q <= s_cmp_d;
            status_q <= status_d;
            enable_q <= enable_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
        end
    end

    assign spi_dout = dout_q;
    assign spi_dout_oe = oe_q;
    assign comp_out = comp_q;
    assign dac_code = code_q;
    assign dac_enable = dac_en_q;
    assign ext_ctrl_switch = s_ext_q;
    assign dac_drive_switch = s_dac_q;
    assign compare_switch = s_cmp_q;
    assign reg_rdata = rdata_q;
    assign irq = irq_q;

endmodule

// ===== hw/step_engine.sv
// saturating up/down step accumulator for the stepped DAC code
`timescale 1ns/1ps
module step_engine
    import atten_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic clock_en,
    step_if.engine steps
);

    logic [9:0] code_q;
    logic [9:0] code_d;
    logic sat_q;
    logic sat_d;
    logic [10:0] sum;

    always_comb
    begin
        code_d = code_q;
        sat_d = 1'b0;
        sum = {1'b0, code_q} + {1'b0, steps.increment};
        if (steps.clear)
        begin
            code_d = CODE_MIN; // R14
        end
        else if (steps.up_step)
        begin
            if (sum[10]) // R11
            begin
                code_d = CODE_MAX;
                sat_d = 1'b1;
            end
            else
            begin
                code_d = sum[9:0]; // R10
            end
        end
        else if (steps.down_step)
        begin
            if (steps.decrement > code_q) // R11
            begin
                code_d = CODE_MIN;
                sat_d = 1'b1;
            end
            else
            begin
                code_d = code_q - steps.decrement; // R10
            end
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            code_q <= CODE_MIN;
            sat_q <= 1'b0;
        end
        else if (clock_en)
        begin
            code_q <= code_d;
            sat_q <= sat_d;
        end
    end

    assign steps.code = code_q;
    assign steps.saturated = sat_q;

endmodule
